//--- exc_regs.vh
// constants for the processor exception sequencer
// How it works
// - exceptions taken only at execute-stage boundaries, access faults at any cycle; later instructions aborted
// - an uninterruptible locked or serialized instruction finishes first
// - step one copies status word, sets supervisor, clears both trace bits
// - reset and interrupt also update the priority mask in step one
// - interrupts get the vector from an acknowledge cycle, others internally
// - every exception but reset stacks a frame on the active supervisor stack
// - interrupt with stack select set clears it and stacks again on interrupt stack
// - vector address is vector base plus four times the vector number
// - program counter loaded from the vector; reset also loads interrupt stack pointer
// - four long words prefetched before normal execution resumes
// - vectors fetched as supervisor data references
// - only the reset vector is fixed; others follow the vector base
// - table of 256 four-byte vectors, 1024 bytes
// - vectors 0-63 for processor exceptions, 64-255 user interrupt vectors
// - reset takes stack pointer from vector 0 and program counter from vector 1
// - vector 2 access fault, vector 3 address error
// - vectors 4-7 illegal, divide by zero, bounds check, conditional trap
// - vectors 8-11 privilege, trace, 1010 and 1111 opcodes
// - vector 14 format error, vector 15 uninitialized interrupt
// - vector 24 spurious, 25-31 autovectors for levels 1-7
// - trap numbers 0-15 map to vectors 32-47
// - bus error on data or fetch raises an access fault
`ifndef EXC_REGS_VH
`define EXC_REGS_VH
// apb register byte offsets
`define OFS_STATUS 8'h00
`define OFS_VBASE 8'h04
`define OFS_ISP 8'h08
`define OFS_MSP 8'h0c
`define OFS_PC 8'h10
`define OFS_INFO 8'h14
// status word fields
`define SW_T1 15
`define SW_T0 14
`define SW_S 13
`define SW_M 12
`define SW_IPM_HI 10
`define SW_IPM_LO 8
`define SW_RESET 16'h2700
`define IPM_MAX 3'h7
// vector numbers
`define VEC_RESET_SP 8'h00
`define VEC_RESET_PC 8'h01
`define VEC_ACCESS 8'h02
`define VEC_ADDRESS 8'h03
`define VEC_ILLEGAL 8'h04
`define VEC_DIVZERO 8'h05
`define VEC_BOUNDS 8'h06
`define VEC_CONDTRAP 8'h07
`define VEC_PRIV 8'h08
`define VEC_TRACE 8'h09
`define VEC_LINE_A 8'h0a
`define VEC_LINE_F 8'h0b
`define VEC_FORMAT 8'h0e
`define VEC_UNINIT 8'h0f
`define VEC_SPURIOUS 8'h18
`define VEC_AUTO_BASE 8'h18
`define VEC_TRAP_BASE 8'h20
`define VEC_USER_BASE 8'h40
// exception cause codes from the pipeline
`define EC_ILLEGAL 4'h0
`define EC_DIVZERO 4'h1
`define EC_BOUNDS 4'h2
`define EC_CONDTRAP 4'h3
`define EC_PRIV 4'h4
`define EC_TRACE 4'h5
`define EC_LINE_A 4'h6
`define EC_LINE_F 4'h7
`define EC_FORMAT 4'h8
`define EC_ADDRESS 4'h9
`define EC_TRAP 4'ha
`define EC_UNINIT 4'hb
// stack frame format codes and last prefetch word index
`define FMT_NORMAL 4'h0
`define FMT_THROW 4'h1
`define PREFETCH_WORDS 2'h3
`endif

//--- processor_exception_sequencer.v
// exception sequencer: status update, vector fetch, stacking, prefetch, apb registers
`timescale 1ns/10ps
`include "exc_regs.vh"
module processor_exception_sequencer (
  input wire clk_sys,
  input wire rst_b,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire insn_boundary,
  input wire insn_locked,
  input wire exc_req,
  input wire [3:0] exc_code,
  input wire [3:0] exc_trap_num,
  input wire [31:0] exc_pc,
  input wire [2:0] irq_level,
  input wire fetch_bus_error,
  input wire data_bus_error,
  output reg mem_req,
  output reg mem_write,
  output reg [31:0] mem_addr,
  output reg [31:0] mem_wdata,
  output reg mem_super,
  output reg mem_data_ref,
  output reg mem_iack,
  output reg [2:0] mem_iack_level,
  input wire [31:0] mem_rdata,
  input wire mem_ack,
  input wire mem_err,
  input wire mem_autovec,
  output reg pipe_abort,
  output reg exc_ack,
  output reg resume,
  output reg [31:0] resume_pc,
  output reg halted,
  output wire supervisor
);

// ==========================================================
// state
localparam ST_IDLE = 3'd0;
localparam ST_SAVE = 3'd1;
localparam ST_IACK = 3'd2;
localparam ST_STACK = 3'd3;
localparam ST_VEC = 3'd4;
localparam ST_PREF = 3'd5;
localparam ST_HALT = 3'd6;

reg [2:0] state;
reg [15:0] status_word;
reg [15:0] sr_copy;
reg [31:0] vector_base;
reg [31:0] interrupt_stack_pointer;
reg [31:0] master_stack_pointer;
reg [31:0] frame_pc;
reg [7:0] vec;
reg [2:0] irq_taken;
reg [1:0] cnt;
reg kind_reset;
reg kind_irq;
reg reset_pend;
reg fault_pend;

wire [2:0] ipm = status_word[`SW_IPM_HI:`SW_IPM_LO];
wire irq_pend = (irq_level > ipm) || (irq_level == `IPM_MAX);
wire done = mem_req && (mem_ack || mem_err);
wire [31:0] act_sp = status_word[`SW_M] ? master_stack_pointer : interrupt_stack_pointer;
wire [31:0] vec_addr = vector_base + {22'h0, vec, 2'b00};
wire sw_access = psel && penable;
wire sw_wr = sw_access && pwrite && (state == ST_IDLE);
wire bus_err_in = fetch_bus_error || data_bus_error;
wire may_take = insn_boundary && !insn_locked;
wire take_fault = fault_pend;
wire take_exc = !fault_pend && may_take && exc_req;
wire take_irq = !fault_pend && may_take && !exc_req && irq_pend;
wire start = (state == ST_IDLE) && !reset_pend && (take_fault || take_exc || take_irq);

assign supervisor = status_word[`SW_S];
assign pready = 1'b1;
assign pslverr = sw_access && (paddr > `OFS_INFO || paddr[1:0] != 2'b00);

// ==========================================================
// cause to vector
function [7:0] cause_vec;
  input [3:0] code;
  input [3:0] trap;
  begin
    case (code)
      `EC_ILLEGAL: cause_vec = `VEC_ILLEGAL;
      `EC_DIVZERO: cause_vec = `VEC_DIVZERO;
      `EC_BOUNDS: cause_vec = `VEC_BOUNDS;
      `EC_CONDTRAP: cause_vec = `VEC_CONDTRAP;
      `EC_PRIV: cause_vec = `VEC_PRIV;
      `EC_TRACE: cause_vec = `VEC_TRACE;
      `EC_LINE_A: cause_vec = `VEC_LINE_A;
      `EC_LINE_F: cause_vec = `VEC_LINE_F;
      `EC_FORMAT: cause_vec = `VEC_FORMAT;
      `EC_UNINIT: cause_vec = `VEC_UNINIT;
      `EC_ADDRESS: cause_vec = `VEC_ADDRESS;
      `EC_TRAP: cause_vec = `VEC_TRAP_BASE + {4'h0, trap};
      default: cause_vec = `VEC_ILLEGAL;
    endcase
  end
endfunction

// ==========================================================
// apb read data, captured in the setup phase
always @(posedge clk_sys or negedge rst_b) begin
  if (!rst_b) begin
    prdata <= 32'h0;
  end else if (psel && !penable) begin
    case (paddr)
      `OFS_STATUS: prdata <= {16'h0, status_word};
      `OFS_VBASE: prdata <= vector_base;
      `OFS_ISP: prdata <= interrupt_stack_pointer;
      `OFS_MSP: prdata <= master_stack_pointer;
      `OFS_PC: prdata <= resume_pc;
      `OFS_INFO: prdata <= {16'h0, 1'b0, state, halted, kind_reset, kind_irq, fault_pend, vec};
      default: prdata <= 32'h0;
    endcase
  end
end

// ==========================================================
// pending flags; a new bus error wins over the clear
always @(posedge clk_sys or negedge rst_b) begin
  if (!rst_b) begin
    fault_pend <= 1'b0;
  end else if (bus_err_in) begin
    fault_pend <= 1'b1;
  end else if (start && take_fault) begin
    fault_pend <= 1'b0;
  end
end

// ==========================================================
// status word
always @(posedge clk_sys or negedge rst_b) begin
  if (!rst_b) begin
    status_word <= `SW_RESET;
    sr_copy <= 16'h0;
  end else if (state == ST_SAVE) begin
    sr_copy <= status_word;
    status_word[`SW_S] <= 1'b1;
    status_word[`SW_T1] <= 1'b0;
    status_word[`SW_T0] <= 1'b0;
    if (kind_reset) begin
      status_word[`SW_IPM_HI:`SW_IPM_LO] <= `IPM_MAX;
      status_word[`SW_M] <= 1'b0;
    end else if (kind_irq) begin
      status_word[`SW_IPM_HI:`SW_IPM_LO] <= irq_taken;
    end
  end else if (state == ST_STACK && done && !mem_err && cnt[0] && kind_irq
               && status_word[`SW_M]) begin
    status_word[`SW_M] <= 1'b0;
  end else if (sw_wr && paddr == `OFS_STATUS) begin
    status_word <= pwdata[15:0];
  end
end

// ==========================================================
// vector base and stack pointers
always @(posedge clk_sys or negedge rst_b) begin
  if (!rst_b) begin
    vector_base <= 32'h0;
    interrupt_stack_pointer <= 32'h0;
    master_stack_pointer <= 32'h0;
  end else begin
    if (sw_wr && paddr == `OFS_VBASE)
      vector_base <= pwdata;
    if (state == ST_STACK && done && !mem_err && cnt[0]) begin
      if (status_word[`SW_M])
        master_stack_pointer <= master_stack_pointer - 32'h8;
      else
        interrupt_stack_pointer <= interrupt_stack_pointer - 32'h8;
    end else if (state == ST_VEC && kind_reset && done && !mem_err && !cnt[0]) begin
      interrupt_stack_pointer <= mem_rdata;
    end else begin
      if (sw_wr && paddr == `OFS_ISP)
        interrupt_stack_pointer <= pwdata;
      if (sw_wr && paddr == `OFS_MSP)
        master_stack_pointer <= pwdata;
    end
  end
end

// ==========================================================
// sequencer
always @(posedge clk_sys or negedge rst_b) begin
  if (!rst_b) begin
    state <= ST_IDLE;
    reset_pend <= 1'b1;
    kind_reset <= 1'b0;
    kind_irq <= 1'b0;
    vec <= 8'h0;
    irq_taken <= 3'h0;
    cnt <= 2'h0;
    frame_pc <= 32'h0;
    resume_pc <= 32'h0;
    pipe_abort <= 1'b0;
    exc_ack <= 1'b0;
    resume <= 1'b0;
    halted <= 1'b0;
    mem_req <= 1'b0;
    mem_write <= 1'b0;
    mem_addr <= 32'h0;
    mem_wdata <= 32'h0;
    mem_super <= 1'b0;
    mem_data_ref <= 1'b0;
    mem_iack <= 1'b0;
    mem_iack_level <= 3'h0;
  end else begin
    pipe_abort <= 1'b0;
    exc_ack <= 1'b0;
    resume <= 1'b0;
    if (done)
      mem_req <= 1'b0;
    case (state)
      ST_IDLE: begin
        cnt <= 2'h0;
        if (reset_pend) begin
          reset_pend <= 1'b0;
          kind_reset <= 1'b1;
          kind_irq <= 1'b0;
          state <= ST_SAVE;
        end else if (start) begin
          pipe_abort <= 1'b1;
          exc_ack <= 1'b1;
          frame_pc <= exc_pc;
          kind_reset <= 1'b0;
          kind_irq <= take_irq;
          irq_taken <= irq_level;
          if (take_fault)
            vec <= `VEC_ACCESS;
          else
            vec <= cause_vec(exc_code, exc_trap_num);
          state <= ST_SAVE;
        end
      end
      ST_SAVE: begin
        if (kind_reset)
          state <= ST_VEC;
        else if (kind_irq)
          state <= ST_IACK;
        else
          state <= ST_STACK;
      end
      ST_IACK: begin
        if (!mem_req && !done) begin
          mem_req <= 1'b1;
          mem_write <= 1'b0;
          mem_iack <= 1'b1;
          mem_iack_level <= irq_taken;
          mem_super <= 1'b1;
          mem_data_ref <= 1'b1;
          mem_addr <= 32'h0;
        end
        if (done) begin
          mem_iack <= 1'b0;
          if (mem_err)
            vec <= `VEC_SPURIOUS;
          else if (mem_autovec)
            vec <= `VEC_AUTO_BASE + {5'h0, irq_taken};
          else
            vec <= mem_rdata[7:0];
          state <= ST_STACK;
        end
      end
      ST_STACK: begin
        if (!mem_req && !done) begin
          mem_req <= 1'b1;
          mem_write <= 1'b1;
          mem_super <= 1'b1;
          mem_data_ref <= 1'b1;
          if (!cnt[0]) begin
            mem_addr <= act_sp - 32'h4;
            mem_wdata <= frame_pc;
          end else begin
            mem_addr <= act_sp - 32'h8;
            mem_wdata <= {sr_copy, (cnt[1] ? `FMT_THROW : `FMT_NORMAL), 2'b00, vec, 2'b00};
          end
        end
        if (done) begin
          if (mem_err) begin
            state <= ST_HALT;
          end else if (!cnt[0]) begin
            cnt <= {cnt[1], 1'b1};
          end else if (kind_irq && status_word[`SW_M]) begin
            cnt <= 2'h2;
          end else begin
            cnt <= 2'h0;
            state <= ST_VEC;
          end
        end
      end
      ST_VEC: begin
        if (!mem_req && !done) begin
          mem_req <= 1'b1;
          mem_write <= 1'b0;
          mem_super <= 1'b1;
          mem_data_ref <= 1'b1;
          if (kind_reset)
            mem_addr <= {22'h0, (cnt[0] ? `VEC_RESET_PC : `VEC_RESET_SP), 2'b00};
          else
            mem_addr <= vec_addr;
        end
        if (done) begin
          if (mem_err) begin
            state <= ST_HALT;
          end else if (kind_reset && !cnt[0]) begin
            cnt <= 2'h1;
          end else begin
            resume_pc <= mem_rdata;
            cnt <= 2'h0;
            state <= ST_PREF;
          end
        end
      end
      ST_PREF: begin
        if (!mem_req && !done) begin
          mem_req <= 1'b1;
          mem_write <= 1'b0;
          mem_super <= 1'b1;
          mem_data_ref <= 1'b0;
          mem_addr <= resume_pc + {28'h0, cnt, 2'b00};
        end
        if (done) begin
          if (mem_err) begin
            state <= ST_HALT;
          end else if (cnt == `PREFETCH_WORDS) begin
            resume <= 1'b1;
            cnt <= 2'h0;
            state <= ST_IDLE;
          end else begin
            cnt <= cnt + 2'h1;
          end
        end
      end
      ST_HALT: begin
        // a fault while sequencing cannot be recovered here; only reset leaves
        halted <= 1'b1;
      end
      default: begin
        state <= ST_HALT;
      end
    endcase
  end
end

endmodule // processor_exception_sequencer

//--- exc_seq_properties.sv
// port checker for the exception sequencer
`timescale 1ns/10ps
module exc_seq_properties (
  input wire clk_sys,
  input wire rst_b,
  input wire mem_req,
  input wire mem_write,
  input wire [31:0] mem_addr,
  input wire mem_super,
  input wire mem_data_ref,
  input wire mem_iack,
  input wire mem_ack,
  input wire mem_err,
  input wire pipe_abort,
  input wire exc_ack,
  input wire resume,
  input wire halted,
  input wire supervisor
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  // ==========================================================
  // prefetch count since the last resume
  reg [2:0] pf_cnt;
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      pf_cnt <= 3'h0;
    end else if (resume) begin
      pf_cnt <= 3'h0;
    end else if (mem_req && mem_ack && !mem_write && !mem_data_ref && !mem_iack) begin
      pf_cnt <= pf_cnt + 3'h1;
    end
  end
  // ==========================================================
  // assertions
  a_super_space: assert property (mem_req |-> mem_super)
    else $error("bus request outside supervisor space");
  a_ack_abort: assert property (exc_ack |-> pipe_abort)
    else $error("accept without pipeline abort");
  a_ack_once: assert property (exc_ack |=> !exc_ack)
    else $error("accept pulse longer than one cycle");
  a_enter_super: assert property (exc_ack |-> ##[1:3] supervisor)
    else $error("supervisor state not entered");
  a_req_hold: assert property (mem_req && !mem_ack && !mem_err |=>
    mem_req && $stable(mem_addr) && $stable(mem_write))
    else $error("bus request changed before answer");
  a_req_gap: assert property (mem_req && (mem_ack || mem_err) |=> !mem_req)
    else $error("no idle cycle between transfers");
  a_iack_read: assert property (mem_req && mem_iack |-> !mem_write)
    else $error("acknowledge cycle is a write");
  a_resume_once: assert property (resume |=> !resume)
    else $error("resume pulse longer than one cycle");
  a_prefetch_four: assert property (resume |-> pf_cnt == 3'h4)
    else $error("resume without four prefetches");
  a_halt_sticky: assert property (halted |=> halted)
    else $error("halt left without reset");
  cover property (exc_ack);
  cover property (mem_req && mem_iack && mem_ack);
  cover property (resume);
  cover property (halted);
endmodule // exc_seq_properties

bind processor_exception_sequencer exc_seq_properties chk (.clk_sys, .rst_b, .mem_req,
  .mem_write, .mem_addr, .mem_super, .mem_data_ref, .mem_iack, .mem_ack, .mem_err,
  .pipe_abort, .exc_ack, .resume, .halted, .supervisor);

//--- exc_mem_model.sv
// memory and interrupt source model beyond the sequencer bus
`timescale 1ns/10ps
module exc_mem_model (
  input wire clk_sys,
  input wire rst_b,
  input wire mem_req,
  input wire mem_write,
  input wire [31:0] mem_addr,
  input wire [31:0] mem_wdata,
  input wire mem_iack,
  input wire [2:0] mem_iack_level,
  input wire [3:0] lat,
  input wire auto_en,
  input wire [7:0] user_vec,
  input wire [1:0] err_mode,
  output reg [31:0] mem_rdata,
  output reg mem_ack,
  output reg mem_err,
  output reg mem_autovec,
  output reg [31:0] wr_a,
  output reg [31:0] wr_b,
  output reg [7:0] wr_cnt,
  output reg [2:0] seen_level
);
  reg [3:0] wait_cnt;
  // ==========================================================
  // answers; read data reads back as address plus 0x10000, acknowledge cycles return user_vec
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      {mem_ack, mem_err, mem_autovec, wait_cnt, seen_level} <= 10'h0;
      {wr_a, wr_b, wr_cnt, mem_rdata} <= 104'h0;
    end else begin
      mem_ack <= 1'b0;
      mem_err <= 1'b0;
      mem_autovec <= 1'b0;
      // released data lines never keep the last value
      mem_rdata <= ~mem_rdata;
      if (mem_req && !mem_ack && !mem_err && wait_cnt != lat) begin
        wait_cnt <= wait_cnt + 4'h1;
      end else if (mem_req && !mem_ack && !mem_err) begin
        wait_cnt <= 4'h0;
        mem_err <= mem_iack ? err_mode == 2'h1 : err_mode == 2'h2;
        mem_ack <= mem_iack ? err_mode != 2'h1 : err_mode != 2'h2;
        mem_rdata <= mem_addr + 32'h0001_0000;
        if (mem_iack) begin
          seen_level <= mem_iack_level;
          mem_autovec <= auto_en;
          mem_rdata <= {24'h0, user_vec};
        end else if (mem_write) begin
          wr_b <= wr_a;
          wr_a <= mem_wdata;
          wr_cnt <= wr_cnt + 8'h1;
        end
      end
    end
  end
endmodule // exc_mem_model

//--- tb_processor_exception_sequencer.sv
// self-checking bench for the exception sequencer
`timescale 1ns/10ps
`include "exc_regs.vh"
module tb_processor_exception_sequencer;
  reg clk_sys, rst_b, psel, penable, pwrite, insn_boundary, insn_locked, exc_req;
  reg fetch_bus_error, data_bus_error, auto_en, last_err;
  reg [7:0] paddr, user_vec, n;
  reg [31:0] pwdata, exc_pc, vbase, q, frame;
  reg [3:0] exc_code, exc_trap_num, lat;
  reg [2:0] irq_level;
  reg [1:0] err_mode;
  wire [31:0] prdata, mem_addr, mem_wdata, mem_rdata, resume_pc, wr_a, wr_b;
  wire [7:0] wr_cnt;
  wire [2:0] mem_iack_level, seen_level;
  wire pready, pslverr, mem_req, mem_write, mem_iack, mem_ack, mem_err, mem_autovec;
  wire pipe_abort, exc_ack, resume, halted, supervisor;
  integer bad_count = 0, n_tests = 0, ack_cnt = 0, k, m;
  processor_exception_sequencer dut (.clk_sys, .rst_b, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .insn_boundary, .insn_locked, .exc_req, .exc_code,
    .exc_trap_num, .exc_pc, .irq_level, .fetch_bus_error, .data_bus_error, .mem_req,
    .mem_write, .mem_addr, .mem_wdata, .mem_super(), .mem_data_ref(), .mem_iack,
    .mem_iack_level, .mem_rdata, .mem_ack, .mem_err, .mem_autovec, .pipe_abort, .exc_ack,
    .resume, .resume_pc, .halted, .supervisor);
  exc_mem_model mem (.clk_sys, .rst_b, .mem_req, .mem_write, .mem_addr, .mem_wdata,
    .mem_iack, .mem_iack_level, .lat, .auto_en, .user_vec, .err_mode, .mem_rdata, .mem_ack,
    .mem_err, .mem_autovec, .wr_a, .wr_b, .wr_cnt, .seen_level);
  // ==========================================================
  // tasks
  task check(input string what, input logic [31:0] got, input logic [31:0] exp);
    n_tests = n_tests + 1;
    if (got !== exp) begin
      bad_count = bad_count + 1;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, a, d};
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    // only the watchdog ends a wait for the slave
    while (pready !== 1'b1) @(posedge clk_sys);
    q = prdata;
    last_err = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  task wait_resume(input logic [7:0] vec);
    integer i;
    for (i = 0; i < 400 && resume !== 1'b1; i = i + 1) @(posedge clk_sys);
    check("resume", {31'h0, resume}, 32'h1);
    check("resume_pc", resume_pc, vbase + {22'h0, vec, 2'b00} + 32'h0001_0000);
  endtask
  task expect_exc(input logic [7:0] vec, input logic [15:0] sw);
    integer i;
    for (i = 0; i < 400 && exc_ack !== 1'b1; i = i + 1) @(posedge clk_sys);
    check("exc_ack", {31'h0, exc_ack}, 32'h1);
    {exc_req, irq_level} <= 4'h0;
    wait_resume(vec);
    apb(1'b0, `OFS_STATUS, 32'h0);
    check("status", q & 32'hffff, {16'h0, sw});
  endtask
  function [7:0] vec_of(input [3:0] c, input [3:0] t);
    case (c)
      4'h8: vec_of = 8'h0e;
      4'h9: vec_of = 8'h03;
      4'ha: vec_of = 8'h20 + {4'h0, t};
      4'hb: vec_of = 8'h0f;
      default: vec_of = 8'h04 + {4'h0, c};
    endcase
  endfunction
  task stop_test;
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // ==========================================================
  // clock, watchdog, sequence
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) if (exc_ack === 1'b1) ack_cnt <= ack_cnt + 1;
  initial begin
    #400000;
    bad_count = bad_count + 1;
    stop_test;
  end
  initial begin
    {rst_b, psel, penable, pwrite, insn_boundary, insn_locked, exc_req} = 7'h0;
    {fetch_bus_error, data_bus_error, auto_en, paddr, user_vec, pwdata, exc_pc} = 83'h0;
    {exc_code, exc_trap_num, lat, irq_level, err_mode, vbase} = 49'h0;
    for (m = 0; m < 2; m = m + 1) begin
      repeat (12) @(posedge clk_sys);
      rst_b <= 1'b1;
      vbase = 32'h0;
      wait_resume(8'h01);
      apb(1'b0, `OFS_ISP, 32'h0);
      check("isp", q, 32'h0001_0000);
      apb(1'b0, `OFS_STATUS, 32'h0);
      check("reset_status", q, 32'h0000_2700);
      check("halted", {31'h0, halted}, 32'h0);
      if (m == 0) begin
        apb(1'b0, 8'h18, 32'h0);
        check("unmapped", {31'h0, last_err}, 32'h1);
        vbase = 32'h0000_2000;
        apb(1'b1, `OFS_VBASE, vbase);
        lat <= 4'h2;
        insn_boundary <= 1'b1;
        for (k = 0; k < 13; k = k + 1) begin
          exc_code <= (k == 12) ? 4'ha : k[3:0];
          exc_trap_num <= (k == 12) ? 4'hf : 4'h0;
          apb(1'b1, `OFS_STATUS, 32'h0000_c000);
          exc_pc <= 32'h0000_0400 + k;
          exc_req <= 1'b1;
          expect_exc(vec_of(exc_code, exc_trap_num), 16'h2000);
          frame = {16'hc000, 6'h0, vec_of(exc_code, exc_trap_num), 2'b00};
          check("frame", {31'h0, wr_a === frame || wr_b === frame}, 32'h1);
        end
        {insn_boundary, exc_code, exc_req} <= 6'h01;
        k = ack_cnt;
        repeat (10) @(posedge clk_sys);
        check("early_take", ack_cnt, k);
        {insn_boundary, insn_locked} <= 2'b11;
        repeat (10) @(posedge clk_sys);
        check("locked_take", ack_cnt, k);
        insn_locked <= 1'b0;
        expect_exc(8'h04, 16'h2000);
        auto_en <= 1'b1;
        irq_level <= 3'h3;
        expect_exc(8'h1b, 16'h2300);
        check("iack_level", {29'h0, seen_level}, 32'h3);
        apb(1'b1, `OFS_STATUS, 32'h0000_3000);
        n = wr_cnt;
        {auto_en, user_vec, irq_level} <= {1'b0, 8'h40, 3'h5};
        expect_exc(8'h40, 16'h2500);
        check("frame_writes", {24'h0, wr_cnt - n}, 32'h4);
        apb(1'b1, `OFS_STATUS, 32'h0000_2000);
        {err_mode, irq_level} <= {2'h1, 3'h2};
        expect_exc(8'h18, 16'h2200);
        {err_mode, lat, insn_boundary} <= 7'h0;
        for (k = 0; k < 2; k = k + 1) begin
          {fetch_bus_error, data_bus_error} <= (k == 0) ? 2'b01 : 2'b10;
          @(posedge clk_sys);
          {fetch_bus_error, data_bus_error} <= 2'b00;
          expect_exc(8'h02, 16'h2200);
        end
        {err_mode, insn_boundary, exc_req} <= 4'hb;
        repeat (30) @(posedge clk_sys);
        check("halted", {31'h0, halted}, 32'h1);
        {rst_b, err_mode, exc_req} <= 4'h0;
      end
    end
    stop_test;
  end
endmodule // tb_processor_exception_sequencer
